// ---- hdl/ars_params.svh ----
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH

// ----------------------------------------
// time base
// ----------------------------------------
`define ARS_CLK_PERIOD_NS 5
`define ARS_TICK_MS 1
`define ARS_MS_CYCLES ((`ARS_TICK_MS * 1000000) / `ARS_CLK_PERIOD_NS)
`define ARS_STEP_MS 10
`define ARS_TIME_W 17

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ARS_ADDR_W 8
`define ARS_CTRL_ADDR 8'h00
`define ARS_STAT_ADDR 8'h04
`define ARS_TIME_BASE 8'h10
`define ARS_TIME_END 8'h58
`define ARS_TIME_BASE_IDX 5'h04
`define ARS_NUM_TIMES 18
`define ARS_CTRL_RESET 16'h0003
`define ARS_CTRL_CLR_BIT 15

// ----------------------------------------
// time setting indices
// ----------------------------------------
`define ARS_S_RECLAIM 5'h00
`define ARS_S_CLOSE 5'h01
`define ARS_S_DYNBLK 5'h02
`define ARS_S_MCBLK 5'h03
`define ARS_S_ACTION 5'h04
`define ARS_S_STARTMAX 5'h05
`define ARS_S_DTDELAY 5'h06
`define ARS_S_CBSUP 5'h07
`define ARS_S_SYNC1 5'h08
`define ARS_S_SYNC2 5'h09
`define ARS_S_DT1PH 5'h0A
`define ARS_S_DT3PH 5'h0E

// ----------------------------------------
// time setting reset values, 10 ms units
// ----------------------------------------
`define ARS_D_RECLAIM 17'h0_00C8
`define ARS_D_CLOSE 17'h0_000A
`define ARS_D_DYNBLK 17'h0_0096
`define ARS_D_MCBLK 17'h0_0064
`define ARS_D_ACTION 17'h0_0064
`define ARS_D_STARTMAX 17'h0_0064
`define ARS_D_DTDELAY 17'h0_012C
`define ARS_D_CBSUP 17'h0_0064
`define ARS_D_SYNC1 17'h0_03E8
`define ARS_D_SYNC2 17'h0_03E8
`define ARS_D_DT1PH 17'h0_0064
`define ARS_D_DT3PH1 17'h0_0032
`define ARS_D_DT3PH2 17'h0_003C
`define ARS_D_DT3PH3 17'h0_0046
`define ARS_D_DT3PH4 17'h0_0050

// ----------------------------------------
// timer slots
// ----------------------------------------
`define ARS_NUM_TMR 8
`define ARS_T_ACT 0
`define ARS_T_START 1
`define ARS_T_DTDEL 2
`define ARS_T_SEQ 3
`define ARS_T_CLOSE 4
`define ARS_T_RECL 5
`define ARS_T_DYN 6
`define ARS_T_MC 7

`endif

// ---- hdl/ars_pkg.sv ----
package ars_pkg;

  typedef enum logic [3:0] {
    ArsIdle,
    ArsAction,
    ArsTrip,
    ArsDtDelay,
    ArsDead,
    ArsCbWait,
    ArsSyncWait,
    ArsSyncSwitch,
    ArsReclaim,
    ArsDynBlock
  } arsState_t;

  typedef struct packed {
    logic general_block_in;
    logic breaker_open_in;
    logic dead_time_delay_in;
    logic manual_close_in;
    logic sync_release_in;
    logic breaker_ready_in;
    logic reduced_dead_time_in;
    logic three_phase_trip_in;
    logic reclose_start_in;
    logic protection_start_in;
  } arsIn_t;

  typedef struct packed {
    logic trip_accelerate_out;
    logic sync_switch_close_request;
    logic blocked_out;
    logic final_trip_out;
    logic close_command_out;
  } arsOut_t;

  typedef struct packed {
    logic [4:0] reserved;
    logic [3:0] accelEn;
    logic cbMonitor;
    logic evolving_fault_policy;
    logic disable_three_phase_reclose;
    logic [2:0] cycle_count_select;
    logic enable;
  } arsCtrl_t;

endpackage

// ---- hdl/ars_timer.sv ----
`timescale 1ns/1ps
`include "ars_params.svh"

module ars_timer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic syncClr,
  input wire logic stepTick,
  input wire logic load,
  input wire logic [`ARS_TIME_W-1:0] loadVal,
  output logic running,
  output logic expired
);

  logic [`ARS_TIME_W-1:0] count;

  // ----------------------------------------
  // down counter in 10 ms steps
  // ----------------------------------------
  // a load of 0 or 1 expires on the next step tick
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 17'h0_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (syncClr) begin
      count <= 17'h0_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      count <= loadVal;
      running <= 1'b1;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (running && stepTick) begin
        if (count <= 17'h0_0001) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - 17'h0_0001;
        end
      end
    end
  end

endmodule

// ---- hdl/ars_seq.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ars_params.svh"

// What this block does
// - reduced dead time input ends the dead time at once
// - single-phase dead time unless three-phase trip selects three-phase time
// - after one three-phase dead time, later cycles stay three-phase
// - three-phase trip present at reclose start with three-phase reclose disabled blocks dynamically
// - wait breaker ready up to supervision time, else dynamic block
// - wait sync release up to its limit, then request synchronous switch
// - synchronous switch has own limit; no closing means dynamic block
// - one close pulse for all phases, width from close time
// - reclaim starts with close, extended until close pulse ends
// - fault in reclaim continues; quiet expiry is success and reset
// - protection start during reclaim keeps sequence alive past reclaim expiry
// - manual close holds not-ready for the post manual close time
// - manual close during a running cycle blocks and resets
// - evolving fault either blocks with final trip or goes three-phase
// - fault after last enabled cycle gives final trip then block
// - new fault in dead time after multi-phase fault gives final trip
// - protection start runs action timer; no trip in time blocks
// - trip acceleration on first start or at enabled cycle dead end
// - dynamic block runs its timer; no close while it runs
// - long start, long delay, start in manual block or general block
// - breaker opening without reclose start under monitoring blocks
// - blocked output high throughout the dynamic blocked state
// - up to four cycles for count settings 1 to 4; settings 5 to 7 wrap the 2-bit cycle count and never reach a last cycle
// - dead time start postponed by delay input up to max delay
// - all time settings count in ten millisecond steps
module ars_seq #(
  parameter int unsigned MS_CYCLES = `ARS_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [`ARS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ars_pkg::arsIn_t pinsIn,
  output ars_pkg::arsOut_t outs
);

  // ----------------------------------------
  // time base
  // ----------------------------------------
  logic [17:0] msCnt;
  logic [3:0] stepCnt;
  logic msTick;
  logic stepTick;
  logic syncClr;

  assign msTick = (msCnt == 18'(MS_CYCLES - 1));
  assign stepTick = msTick && (stepCnt == 4'h9);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      msCnt <= 18'h0_0000;
      stepCnt <= 4'h0;
    end else if (syncClr) begin
      msCnt <= 18'h0_0000;
      stepCnt <= 4'h0;
    end else begin
      msCnt <= msTick ? 18'h0_0000 : msCnt + 18'h0_0001;
      if (msTick) begin
        stepCnt <= stepTick ? 4'h0 : stepCnt + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // input synchroniser and edges
  // ----------------------------------------
  ars_pkg::arsIn_t inMeta;
  ars_pkg::arsIn_t inNow;
  ars_pkg::arsIn_t inPrev;
  ars_pkg::arsIn_t inRise;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      inMeta <= '0;
      inNow <= '0;
      inPrev <= '0;
    end else begin
      inMeta <= pinsIn;
      inNow <= inMeta;
      inPrev <= inNow;
    end
  end

  assign inRise = inNow & ~inPrev;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  ars_pkg::arsCtrl_t ctrl;
  logic [`ARS_TIME_W-1:0] setting [`ARS_NUM_TIMES];
  logic ackd;
  logic [31:0] wMask;
  logic hitCtrl;
  logic hitStat;
  logic hitTime;
  logic [4:0] timeIdx;
  logic [31:0] ctrlWord;
  logic [31:0] statWord;
  logic [31:0] rdMux;
  logic wrNow;

  function automatic logic [`ARS_TIME_W-1:0] timeDefault(input int idx);
    case (idx)
      0: timeDefault = `ARS_D_RECLAIM;
      1: timeDefault = `ARS_D_CLOSE;
      2: timeDefault = `ARS_D_DYNBLK;
      3: timeDefault = `ARS_D_MCBLK;
      4: timeDefault = `ARS_D_ACTION;
      5: timeDefault = `ARS_D_STARTMAX;
      6: timeDefault = `ARS_D_DTDELAY;
      7: timeDefault = `ARS_D_CBSUP;
      8: timeDefault = `ARS_D_SYNC1;
      9: timeDefault = `ARS_D_SYNC2;
      14: timeDefault = `ARS_D_DT3PH1;
      15: timeDefault = `ARS_D_DT3PH2;
      16: timeDefault = `ARS_D_DT3PH3;
      17: timeDefault = `ARS_D_DT3PH4;
      default: timeDefault = `ARS_D_DT1PH;
    endcase
  endfunction

  // one wait state: request seen, then answered on the next edge
  assign avs_waitrequest = (avs_read || avs_write) && !ackd;
  assign wrNow = avs_write && ackd;
  assign wMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign hitCtrl = (avs_address == `ARS_CTRL_ADDR);
  assign hitStat = (avs_address == `ARS_STAT_ADDR);
  assign hitTime = (avs_address[1:0] == 2'h0) && (avs_address >= `ARS_TIME_BASE)
                   && (avs_address < `ARS_TIME_END);
  assign timeIdx = avs_address[6:2] - `ARS_TIME_BASE_IDX;
  assign ctrlWord = {16'h0000, 5'h00, ctrl[10:0]};
  assign rdMux = hitCtrl ? ctrlWord :
                 hitStat ? statWord :
                 hitTime ? {15'h0000, setting[timeIdx]} : 32'h0000_0000;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ackd <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ackd <= (avs_read || avs_write) && !ackd;
      if (avs_read && !ackd) begin
        avs_readdata <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `ARS_CTRL_RESET;
      syncClr <= 1'b0;
      for (int i = 0; i < `ARS_NUM_TIMES; i++) begin
        setting[i] <= timeDefault(i);
      end
    end else begin
      syncClr <= wrNow && hitCtrl && avs_byteenable[1] && avs_writedata[`ARS_CTRL_CLR_BIT];
      if (wrNow && hitCtrl) begin
        ctrl <= (ctrl & ~wMask[15:0]) | (avs_writedata[15:0] & wMask[15:0]);
      end
      if (wrNow && hitTime) begin
        setting[timeIdx] <= (setting[timeIdx] & ~wMask[16:0]) | (avs_writedata[16:0] & wMask[16:0]);
      end
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic [`ARS_NUM_TMR-1:0] tmrLoad;
  logic [`ARS_NUM_TMR-1:0] tmrRun;
  logic [`ARS_NUM_TMR-1:0] tmrExp;
  logic [`ARS_TIME_W-1:0] tmrVal [`ARS_NUM_TMR];
  logic [4:0] seqSel;

  assign tmrVal[`ARS_T_ACT] = setting[`ARS_S_ACTION];
  assign tmrVal[`ARS_T_START] = setting[`ARS_S_STARTMAX];
  assign tmrVal[`ARS_T_DTDEL] = setting[`ARS_S_DTDELAY];
  assign tmrVal[`ARS_T_SEQ] = setting[seqSel];
  assign tmrVal[`ARS_T_CLOSE] = setting[`ARS_S_CLOSE];
  assign tmrVal[`ARS_T_RECL] = setting[`ARS_S_RECLAIM];
  assign tmrVal[`ARS_T_DYN] = setting[`ARS_S_DYNBLK];
  assign tmrVal[`ARS_T_MC] = setting[`ARS_S_MCBLK];

  for (genvar g = 0; g < `ARS_NUM_TMR; g++) begin : gTmr
    ars_timer uTmr (
      .core_clk(core_clk),
      .reset(reset),
      .syncClr(syncClr),
      .stepTick(stepTick),
      .load(tmrLoad[g]),
      .loadVal(tmrVal[g]),
      .running(tmrRun[g]),
      .expired(tmrExp[g])
    );
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  ars_pkg::arsState_t state, next_state;
  logic [1:0] cycle, next_cycle;
  logic use3ph, next_use3ph;
  logic contSeq, next_contSeq;
  logic startSeen, next_startSeen;
  logic reclDone, next_reclDone;
  ars_pkg::arsOut_t outR, next_outR;
  logic notReady;
  logic running;
  logic lastCycle;
  logic accelHere;

  assign notReady = !ctrl.enable || (ctrl.cycle_count_select == 3'h0) || !inNow.breaker_ready_in
                    || tmrRun[`ARS_T_MC] || (ctrl.cbMonitor && inNow.breaker_open_in)
                    || inNow.general_block_in;
  assign running = (state != ars_pkg::ArsIdle) && (state != ars_pkg::ArsDynBlock);
  assign lastCycle = ({1'b0, cycle} + 3'h1) >= ctrl.cycle_count_select;
  assign accelHere = ctrl.accelEn[cycle];
  assign outs = outR;
  assign statWord = {16'h0000, 3'h0, notReady, use3ph, outR, cycle, state};

  always_comb begin
    logic goDyn;
    logic goFinal;
    logic goTrip;
    logic goNext;
    logic goClose;
    logic deadLoad;
    goDyn = 1'b0;
    goFinal = 1'b0;
    goTrip = 1'b0;
    goNext = 1'b0;
    goClose = 1'b0;
    deadLoad = 1'b0;
    next_state = state;
    next_cycle = cycle;
    next_use3ph = use3ph;
    next_contSeq = contSeq;
    next_startSeen = startSeen;
    next_reclDone = reclDone;
    next_outR = outR;
    seqSel = `ARS_S_CBSUP;
    tmrLoad = '0;
    tmrLoad[`ARS_T_MC] = inRise.manual_close_in;
    case (state)
      ars_pkg::ArsIdle: begin
        if (inRise.reclose_start_in) begin
          // start in manual block or general block
          if (tmrRun[`ARS_T_MC] || inNow.general_block_in) begin
            goDyn = 1'b1;
          end else if (!notReady) begin
            next_cycle = 2'h0;
            goTrip = 1'b1;
          end
        end else if (inRise.protection_start_in && !notReady) begin
          next_state = ars_pkg::ArsAction;
          tmrLoad[`ARS_T_ACT] = 1'b1;
          next_contSeq = 1'b0;
          next_cycle = 2'h0;
          next_outR.trip_accelerate_out = ctrl.accelEn[0];
        end
      end
      ars_pkg::ArsAction: begin
        if (inRise.reclose_start_in) begin
          if (contSeq) begin
            goNext = 1'b1;
          end else begin
            next_cycle = 2'h0;
            goTrip = 1'b1;
          end
        end else if (tmrExp[`ARS_T_ACT]) begin
          goDyn = 1'b1;
        end
      end
      ars_pkg::ArsTrip: begin
        if (inRise.three_phase_trip_in && !use3ph) begin
          if (!ctrl.evolving_fault_policy) begin
            goFinal = 1'b1;
          end else begin
            next_use3ph = 1'b1;
          end
        end else if (tmrExp[`ARS_T_START] && inNow.reclose_start_in) begin
          goDyn = 1'b1;
        end else if (!inNow.reclose_start_in) begin
          if (inNow.dead_time_delay_in) begin
            next_state = ars_pkg::ArsDtDelay;
            tmrLoad[`ARS_T_DTDEL] = 1'b1;
          end else begin
            deadLoad = 1'b1;
          end
        end
      end
      ars_pkg::ArsDtDelay: begin
        if (!inNow.dead_time_delay_in) begin
          deadLoad = 1'b1;
        end else if (tmrExp[`ARS_T_DTDEL]) begin
          goDyn = 1'b1;
        end
      end
      ars_pkg::ArsDead: begin
        if (inRise.reclose_start_in && use3ph) begin
          goFinal = 1'b1;
        end else if (inRise.reclose_start_in && inNow.three_phase_trip_in) begin
          if (!ctrl.evolving_fault_policy) begin
            goFinal = 1'b1;
          end else begin
            next_use3ph = 1'b1;
            next_state = ars_pkg::ArsTrip;
            tmrLoad[`ARS_T_START] = 1'b1;
          end
        end else if (inNow.reduced_dead_time_in || tmrExp[`ARS_T_SEQ]) begin
          next_outR.trip_accelerate_out = outR.trip_accelerate_out || accelHere;
          next_state = ars_pkg::ArsCbWait;
          tmrLoad[`ARS_T_SEQ] = 1'b1;
          seqSel = `ARS_S_CBSUP;
        end
      end
      ars_pkg::ArsCbWait: begin
        if (inNow.breaker_ready_in) begin
          next_state = ars_pkg::ArsSyncWait;
          tmrLoad[`ARS_T_SEQ] = 1'b1;
          seqSel = `ARS_S_SYNC1;
        end else if (tmrExp[`ARS_T_SEQ]) begin
          goDyn = 1'b1;
        end
      end
      ars_pkg::ArsSyncWait: begin
        if (inNow.sync_release_in) begin
          goClose = 1'b1;
        end else if (tmrExp[`ARS_T_SEQ]) begin
          next_state = ars_pkg::ArsSyncSwitch;
          next_outR.sync_switch_close_request = 1'b1;
          tmrLoad[`ARS_T_SEQ] = 1'b1;
          seqSel = `ARS_S_SYNC2;
        end
      end
      ars_pkg::ArsSyncSwitch: begin
        // closing seen as breaker no longer open
        if (!inNow.breaker_open_in) begin
          next_outR.sync_switch_close_request = 1'b0;
          next_state = ars_pkg::ArsReclaim;
          next_reclDone = 1'b0;
          next_startSeen = 1'b0;
          tmrLoad[`ARS_T_RECL] = 1'b1;
        end else if (tmrExp[`ARS_T_SEQ]) begin
          goDyn = 1'b1;
        end
      end
      ars_pkg::ArsReclaim: begin
        if (tmrExp[`ARS_T_RECL]) begin
          next_reclDone = 1'b1;
        end
        if (inRise.protection_start_in) begin
          next_startSeen = 1'b1;
          next_outR.trip_accelerate_out = outR.trip_accelerate_out || accelHere;
        end
        if (inRise.reclose_start_in) begin
          goNext = 1'b1;
        end else if (reclDone && !outR.close_command_out) begin
          if (startSeen) begin
            next_state = ars_pkg::ArsAction;
            next_contSeq = 1'b1;
            tmrLoad[`ARS_T_ACT] = 1'b1;
          end else begin
            next_state = ars_pkg::ArsIdle;
          end
        end
      end
      ars_pkg::ArsDynBlock: begin
        if (tmrExp[`ARS_T_DYN]) begin
          next_state = ars_pkg::ArsIdle;
        end
      end
      default: begin
        next_state = ars_pkg::ArsIdle;
      end
    endcase
    if (goNext) begin
      if (lastCycle) begin
        goFinal = 1'b1;
      end else begin
        next_cycle = cycle + 2'h1;
        goTrip = 1'b1;
      end
    end
    if (goTrip) begin
      next_use3ph = (goNext ? use3ph : 1'b0) || inNow.three_phase_trip_in;
      next_state = ars_pkg::ArsTrip;
      tmrLoad[`ARS_T_START] = 1'b1;
      if (inNow.three_phase_trip_in && ctrl.disable_three_phase_reclose) begin
        goDyn = 1'b1;
      end
    end
    if (deadLoad) begin
      next_state = ars_pkg::ArsDead;
      tmrLoad[`ARS_T_SEQ] = 1'b1;
      seqSel = (next_use3ph ? `ARS_S_DT3PH : `ARS_S_DT1PH) + {3'h0, cycle};
    end
    if (goClose) begin
      // one close pulse for all phases
      next_state = ars_pkg::ArsReclaim;
      next_outR.close_command_out = 1'b1;
      next_reclDone = 1'b0;
      next_startSeen = 1'b0;
      tmrLoad[`ARS_T_CLOSE] = 1'b1;
      tmrLoad[`ARS_T_RECL] = 1'b1;
    end
    if (tmrExp[`ARS_T_CLOSE]) begin
      next_outR.close_command_out = 1'b0;
    end
    // manual close in a running cycle
    if (running && inRise.manual_close_in) begin
      goDyn = 1'b1;
    end
    if (running && ctrl.cbMonitor && inRise.breaker_open_in && !inNow.reclose_start_in) begin
      goDyn = 1'b1;
    end
    if (goFinal) begin
      next_outR.final_trip_out = 1'b1;
      goDyn = 1'b1;
    end
    if (goDyn) begin
      next_state = ars_pkg::ArsDynBlock;
      next_outR.close_command_out = 1'b0;
      next_outR.sync_switch_close_request = 1'b0;
      next_outR.trip_accelerate_out = 1'b0;
    end
    if (next_state == ars_pkg::ArsIdle) begin
      next_cycle = 2'h0;
      next_use3ph = 1'b0;
      next_contSeq = 1'b0;
      next_outR.final_trip_out = 1'b0;
      next_outR.trip_accelerate_out = 1'b0;
    end
    tmrLoad[`ARS_T_DYN] = (next_state == ars_pkg::ArsDynBlock) && (state != ars_pkg::ArsDynBlock);
    next_outR.blocked_out = (next_state == ars_pkg::ArsDynBlock) ||
                            ((next_state == ars_pkg::ArsIdle) && notReady);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ars_pkg::ArsIdle;
      cycle <= 2'h0;
      use3ph <= 1'b0;
      contSeq <= 1'b0;
      startSeen <= 1'b0;
      reclDone <= 1'b0;
      outR <= '0;
    end else if (syncClr) begin
      state <= ars_pkg::ArsIdle;
      cycle <= 2'h0;
      use3ph <= 1'b0;
      contSeq <= 1'b0;
      startSeen <= 1'b0;
      reclDone <= 1'b0;
      outR <= '0;
    end else begin
      state <= next_state;
      cycle <= next_cycle;
      use3ph <= next_use3ph;
      contSeq <= next_contSeq;
      startSeen <= next_startSeen;
      reclDone <= next_reclDone;
      outR <= next_outR;
    end
  end

endmodule

// ---- dv/ars_seq_properties.sv ----
`timescale 1ns/1ps
module ars_seq_properties #(
  parameter int unsigned MS_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire ars_pkg::arsIn_t pinsIn,
  input wire ars_pkg::arsOut_t outs
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  localparam int unsigned STEP = 10 * MS_CYCLES;
  logic [15:0] closeLen;
  // ----------------------------------------
  // close pulse length
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) closeLen <= '0;
    else if (outs.close_command_out) closeLen <= closeLen + 16'h0001;
    else closeLen <= '0;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  // bound assumes a close time of two steps
  a_close_max: assert property (closeLen <= 2 * STEP + 8)
    else $error("close pulse too long");
  a_close_min: assert property ($fell(outs.close_command_out) && !outs.blocked_out |-> closeLen >= STEP - 4)
    else $error("close pulse too short");
  a_block_close: assert property (outs.blocked_out |-> !outs.close_command_out)
    else $error("close while blocked");
  a_final_block: assert property ($rose(outs.final_trip_out) |-> ##[0:2] outs.blocked_out)
    else $error("final trip without block");
  a_final_close: assert property (outs.final_trip_out |-> !outs.close_command_out)
    else $error("close with final trip");
  a_sync_close: assert property (outs.sync_switch_close_request |-> !outs.close_command_out)
    else $error("close pulse in sync switch");
  a_manual_block: assert property ($rose(pinsIn.manual_close_in) |-> ##[1:6] outs.blocked_out)
    else $error("manual close not blocking");
  c_close: cover property ($rose(outs.close_command_out));
  c_sync: cover property ($rose(outs.sync_switch_close_request));
  c_block: cover property ($rose(outs.blocked_out));
endmodule

bind ars_seq ars_seq_properties #(.MS_CYCLES(MS_CYCLES)) ars_seq_properties_i (
  .core_clk(core_clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .pinsIn(pinsIn), .outs(outs));

// ---- dv/ars_breaker_model.sv ----
`timescale 1ns/1ps
module ars_breaker_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tripIn,
  input wire logic closeIn,
  output logic breakerOpen,
  output logic breakerReady
);
  // poles open on trip, close on the close pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) breakerOpen <= 1'b0;
    else if (tripIn) breakerOpen <= 1'b1;
    else if (closeIn) breakerOpen <= 1'b0;
  end
  // spring recharge not modelled
  assign breakerReady = 1'b1;
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam int STEP = 200;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ars_pkg::arsIn_t pinsTb = '0;
  ars_pkg::arsIn_t pinsIn;
  ars_pkg::arsOut_t outs;
  logic [4:0] ov;
  logic brkOpen;
  logic brkReady;
  logic [31:0] rd;
  int errCount = 0;
  int checks = 0;
  int cyc = 0;
  assign ov = outs;
  always_comb begin
    pinsIn = pinsTb;
    pinsIn.breaker_open_in = brkOpen;
    pinsIn.breaker_ready_in = brkReady;
  end
  ars_seq #(.MS_CYCLES(20)) ars_seq_i (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pinsIn(pinsIn), .outs(outs));
  ars_breaker_model ars_breaker_model_i (.core_clk(core_clk), .reset(reset), .tripIn(pinsTb.reclose_start_in),
    .closeIn(outs.close_command_out), .breakerOpen(brkOpen), .breakerReady(brkReady));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    if (errCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk iff avs_waitrequest === 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic waitOut(input int idx, input logic lvl, input int lim);
    int n = 0;
    while (ov[idx] !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(ov[idx]), 32'(lvl));
  endtask
  task automatic trip();
    pinsTb.reclose_start_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    pinsTb.reclose_start_in <= 1'b0;
  endtask
  task automatic t_regs();
    rdc(8'h00, 32'h0000_0003);
    rdc(8'h10, 32'h0000_00C8);
    bus(1'b1, 8'h14, 32'h0000_0002);
    rdc(8'h14, 32'h0000_0002);
    rdc(8'h80, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'h0000_0001);
    bus(1'b1, 8'h18, 32'h0000_0001);
    bus(1'b1, 8'h30, 32'h0000_0001);
    bus(1'b1, 8'h34, 32'h0000_0001);
    // acceleration on for the first cycle
    bus(1'b1, 8'h00, 32'h0000_0083);
  endtask
  task automatic t_reclose();
    pinsTb.sync_release_in <= 1'b1;
    pinsTb.reduced_dead_time_in <= 1'b1;
    trip();
    // default dead time is far beyond this bound
    waitOut(0, 1'b1, 3 * STEP);
    chk(32'(ov[4]), 32'h0000_0001);
    waitOut(0, 1'b0, 3 * STEP);
    repeat (3 * STEP) @(posedge core_clk);
    rdc(8'h04, 32'h0000_0000);
  endtask
  task automatic t_sync();
    pinsTb.sync_release_in <= 1'b0;
    trip();
    waitOut(3, 1'b1, 3 * STEP);
    waitOut(2, 1'b1, 3 * STEP);
    chk(32'(ov[0]), 32'h0000_0000);
    waitOut(2, 1'b0, 3 * STEP);
  endtask
  task automatic t_final();
    pinsTb.reduced_dead_time_in <= 1'b0;
    pinsTb.three_phase_trip_in <= 1'b1;
    trip();
    // let the dead time start before the refault
    repeat (5) @(posedge core_clk);
    trip();
    waitOut(1, 1'b1, 16);
    waitOut(1, 1'b0, 3 * STEP);
    pinsTb.three_phase_trip_in <= 1'b0;
  endtask
  task automatic t_manual();
    pinsTb.manual_close_in <= 1'b1;
    waitOut(2, 1'b1, 8);
    rdc(8'h04, 32'h0000_1100);
    bus(1'b1, 8'h00, 32'h0000_8083);
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0083);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_reclose();
    t_sync();
    t_final();
    t_manual();
    tally_and_finish();
  end
endmodule
